/* logic/meter_config_ram_bank.sv */
`timescale 1ns/10ps
`default_nettype none

module meter_config_ram_bank (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    // Processor access
    input wire cfg_ram_pkg::cfg_req_type I_REQ,
    output var logic [7:0] O_RDATA,
    output var logic O_RVALID,
    // Digital input pins 4 to 11
    input wire logic [7:0] I_PIN,
    // Converter and compute engine
    output var logic O_CONVERTER_DISABLE,
    output var logic O_CONVERTER_BIAS_OFF,
    output var logic O_CE_RUN,
    output var logic O_CHOP_ENABLE,
    // Clock test pin
    output var logic O_CLOCK_TEST_PIN,
    output var logic O_CLOCK_TEST_PIN_OE_N,
    // Port 0 direction
    output var logic [3:0] O_PORT0_DIRECTION_BITS,
    // Routed resources
    output var cfg_ram_pkg::route_out_type O_ROUTE
);
    import cfg_ram_pkg::*;

    // Register storage
    logic [7:0] ce_ctrl_q;
    logic [7:0] chop_ctrl_q;
    logic [7:0] resv3_q;
    logic [7:0] ckout_ctrl_q;
    logic [7:0] conv_ctrl_q;
    logic [7:0] dir0_q;
    logic [7:0] route_q [NUM_ROUTE_REGS];

    // Address decode
    wire xd_access = !I_REQ.sfr_space && (I_REQ.addr[15:12] == XDATA_REGION);
    wire sel_dir0 = I_REQ.sfr_space && (I_REQ.addr == ADDR_PORT0_DIRECTION);
    wire sel_ce = xd_access && (I_REQ.addr == ADDR_COMPUTE_ENGINE_CONTROL);
    wire sel_chop = xd_access && (I_REQ.addr == ADDR_REFERENCE_CHOP_CONTROL);
    wire sel_resv3 = xd_access && (I_REQ.addr == ADDR_RESERVED_CONFIG_THREE);
    wire sel_ckout = xd_access && (I_REQ.addr == ADDR_CLOCK_OUTPUT_CONTROL);
    wire sel_conv = xd_access && (I_REQ.addr == ADDR_CONVERTER_POWER_CONTROL);
    wire [NUM_ROUTE_REGS-1:0] sel_route;
    assign sel_route[0] = xd_access && (I_REQ.addr == ADDR_PIN_INPUT_ROUTE_A);
    assign sel_route[1] = xd_access && (I_REQ.addr == ADDR_PIN_INPUT_ROUTE_B);
    assign sel_route[2] = xd_access && (I_REQ.addr == ADDR_PIN_INPUT_ROUTE_C);
    assign sel_route[3] = xd_access && (I_REQ.addr == ADDR_PIN_INPUT_ROUTE_D);

    // Masked write data, read-only bits keep their old value
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wd,
                                         input logic [7:0] mask);
        merge = (wd & mask) | (old & ~mask);
    endfunction

    wire [7:0] ce_ctrl_d = merge(ce_ctrl_q, I_REQ.wdata, MASK_FULL);
    wire [7:0] chop_ctrl_d = merge(chop_ctrl_q, I_REQ.wdata, MASK_FULL);
    wire [7:0] resv3_d =
        merge(resv3_q, I_REQ.wdata, MASK_RESERVED_THREE);
    wire [7:0] ckout_ctrl_d = merge(ckout_ctrl_q, I_REQ.wdata, MASK_FULL);
    wire [7:0] conv_ctrl_d = merge(conv_ctrl_q, I_REQ.wdata, MASK_FULL);
    wire [7:0] dir0_d = merge(dir0_q, I_REQ.wdata, MASK_DIRECTION);

    // Write strobes, unmapped addresses hit nothing
    wire we_ce = I_REQ.write && sel_ce;
    wire we_chop = I_REQ.write && sel_chop;
    wire we_resv3 = I_REQ.write && sel_resv3;
    wire we_ckout = I_REQ.write && sel_ckout;
    wire we_conv = I_REQ.write && sel_conv;
    wire we_dir0 = I_REQ.write && sel_dir0;
    wire [NUM_ROUTE_REGS-1:0] we_route;
    assign we_route[0] = I_REQ.write && sel_route[0];
    assign we_route[1] = I_REQ.write && sel_route[1];
    assign we_route[2] = I_REQ.write && sel_route[2];
    assign we_route[3] = I_REQ.write && sel_route[3];

    // Register writes
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            ce_ctrl_q <= RESET_VALUE;
        end else if (we_ce) begin
            ce_ctrl_q <= ce_ctrl_d;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            chop_ctrl_q <= RESET_VALUE;
        end else if (we_chop) begin
            chop_ctrl_q <= chop_ctrl_d;
        end
    end

    // Only the must-be-zero bits are storable
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            resv3_q <= RESET_VALUE;
        end else if (we_resv3) begin
            resv3_q <= resv3_d;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            ckout_ctrl_q <= RESET_VALUE;
        end else if (we_ckout) begin
            ckout_ctrl_q <= ckout_ctrl_d;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            conv_ctrl_q <= RESET_VALUE;
        end else if (we_conv) begin
            conv_ctrl_q <= conv_ctrl_d;
        end
    end

    // Low nibble of the direction byte reads as ones
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            dir0_q <= RESET_VALUE;
        end else if (we_dir0) begin
            dir0_q <= dir0_d;
        end
    end

    // Route registers, one per pin pair
    genvar r;
    generate
        for (r = 0; r < NUM_ROUTE_REGS; r++) begin : g_route_reg
            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RSTN) begin
                    route_q[r] <= RESET_VALUE;
                end else if (we_route[r]) begin
                    route_q[r] <= merge(route_q[r], I_REQ.wdata,
                                        MASK_ROUTE);
                end
            end
        end
    endgenerate

    // Read mux, unmapped addresses read zero
    wire [7:0] rd_dir0 = {8{sel_dir0}} & (dir0_q | DIRECTION_FIXED_ONES);
    wire [7:0] rd_ce = {8{sel_ce}} & ce_ctrl_q;
    wire [7:0] rd_chop = {8{sel_chop}} & chop_ctrl_q;
    wire [7:0] rd_resv3 = {8{sel_resv3}} & resv3_q;
    wire [7:0] rd_ckout = {8{sel_ckout}} & ckout_ctrl_q;
    wire [7:0] rd_conv = {8{sel_conv}} & conv_ctrl_q;
    wire [7:0] rd_route_a = {8{sel_route[0]}} & route_q[0];
    wire [7:0] rd_route_b = {8{sel_route[1]}} & route_q[1];
    wire [7:0] rd_route_c = {8{sel_route[2]}} & route_q[2];
    wire [7:0] rd_route_d = {8{sel_route[3]}} & route_q[3];
    wire [7:0] rd_mux = rd_dir0 | rd_ce | rd_chop | rd_resv3 | rd_ckout |
        rd_conv | rd_route_a | rd_route_b | rd_route_c | rd_route_d;

    // Read in a write cycle returns the old value
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_RDATA <= 8'h00;
            O_RVALID <= 1'b0;
        end else begin
            O_RVALID <= I_REQ.read;
            if (I_REQ.read) O_RDATA <= rd_mux;
        end
    end

    // Control decode
    wire [1:0] chop_code = chop_ctrl_q[CHOP_LSB+1:CHOP_LSB];
    wire chop_on = (chop_code[1] == chop_code[0]);
    wire conv_off = conv_ctrl_q[CONVERTER_DISABLE_BIT];
    wire ce_on = ce_ctrl_q[CE_ENABLE_BIT];
    wire ck_dis = ckout_ctrl_q[CLOCK_OUTPUT_DISABLE_BIT];
    wire ck_next = ck_dis ? 1'b0 : !O_CLOCK_TEST_PIN;

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_CONVERTER_DISABLE <= 1'b0;
            O_CONVERTER_BIAS_OFF <= 1'b0;
        end else begin
            O_CONVERTER_DISABLE <= conv_off;
            O_CONVERTER_BIAS_OFF <= conv_off;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_CE_RUN <= 1'b0;
        end else begin
            O_CE_RUN <= ce_on;
        end
    end

    // Chop runs after reset, code 00 means on
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_CHOP_ENABLE <= 1'b1;
        end else begin
            O_CHOP_ENABLE <= chop_on;
        end
    end

    // Test clock is the system clock halved
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_CLOCK_TEST_PIN <= 1'b0;
            O_CLOCK_TEST_PIN_OE_N <= 1'b0;
        end else begin
            O_CLOCK_TEST_PIN <= ck_next;
            O_CLOCK_TEST_PIN_OE_N <= ck_dis;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_PORT0_DIRECTION_BITS <= 4'h0;
        end else begin
            O_PORT0_DIRECTION_BITS <= dir0_q[7:4];
        end
    end

    // Pin synchronisers and per-pin resource hits
    logic [NUM_ROUTE_PINS-1:0] pin_meta_q;
    logic [NUM_ROUTE_PINS-1:0] pin_sync_q;
    logic [NUM_ROUTE_PINS-1:0] pin_prev_q;
    logic [NUM_ROUTE_PINS-1:0] hit_count0;
    logic [NUM_ROUTE_PINS-1:0] hit_count1;
    logic [NUM_ROUTE_PINS-1:0] hit_hi;
    logic [NUM_ROUTE_PINS-1:0] hit_lo;

    genvar p;
    generate
        for (p = 0; p < NUM_ROUTE_PINS; p++) begin : g_pin
            // Low field for even pins, high field for odd
            wire [2:0] code = (p % 2 == 0) ?
                route_q[p/2][ROUTE_LO_LSB+2:ROUTE_LO_LSB] :
                route_q[p/2][ROUTE_HI_LSB+2:ROUTE_HI_LSB];
            // Edges against the previous synced sample
            wire rise = pin_sync_q[p] && !pin_prev_q[p];
            wire fall = !pin_sync_q[p] && pin_prev_q[p];

            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RSTN) begin
                    pin_meta_q[p] <= 1'b0;
                    pin_sync_q[p] <= 1'b0;
                    pin_prev_q[p] <= 1'b0;
                end else begin
                    pin_meta_q[p] <= I_PIN[p];
                    pin_sync_q[p] <= pin_meta_q[p];
                    pin_prev_q[p] <= pin_sync_q[p];
                end
            end

            // One-hot view of the field, none and reserved feed nothing
            wire to_count0 = (code == ROUTE_COUNTER_ZERO_CLOCK);
            wire to_count1 = (code == ROUTE_COUNTER_ONE_CLOCK);
            wire to_hi_rise = (code == ROUTE_HIGH_RISING);
            wire to_lo_rise = (code == ROUTE_LOW_RISING);
            wire to_hi_fall = (code == ROUTE_HIGH_FALLING);
            wire to_lo_fall = (code == ROUTE_LOW_FALLING);

            // Each field selects at most one resource, codes none and reserved select none
            assign hit_count0[p] = pin_sync_q[p] && to_count0;
            assign hit_count1[p] = pin_sync_q[p] && to_count1;
            assign hit_hi[p] = (rise && to_hi_rise) ||
                (fall && to_hi_fall);
            assign hit_lo[p] = (rise && to_lo_rise) ||
                (fall && to_lo_fall);
        end
    endgenerate

    // Shared resources take the OR of every routed pin
    route_out_type route_d;
    assign route_d = '{
        counter_zero_clock: |hit_count0,
        counter_one_clock: |hit_count1,
        high_priority_pin_interrupt: |hit_hi,
        low_priority_pin_interrupt: |hit_lo
    };

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_ROUTE <= '0;
        end else begin
            O_ROUTE <= route_d;
        end
    end

endmodule // meter_config_ram_bank

`default_nettype wire

/* common/cfg_ram_pkg.sv */
package cfg_ram_pkg;

    // Address spaces and offsets
    localparam logic [15:0] ADDR_PORT0_DIRECTION = 16'h00a2;
    localparam logic [15:0] ADDR_COMPUTE_ENGINE_CONTROL = 16'h2000;
    localparam logic [15:0] ADDR_REFERENCE_CHOP_CONTROL = 16'h2002;
    localparam logic [15:0] ADDR_RESERVED_CONFIG_THREE = 16'h2003;
    localparam logic [15:0] ADDR_CLOCK_OUTPUT_CONTROL = 16'h2004;
    localparam logic [15:0] ADDR_CONVERTER_POWER_CONTROL = 16'h2005;
    localparam logic [15:0] ADDR_PIN_INPUT_ROUTE_A = 16'h200b;
    localparam logic [15:0] ADDR_PIN_INPUT_ROUTE_B = 16'h200c;
    localparam logic [15:0] ADDR_PIN_INPUT_ROUTE_C = 16'h200d;
    localparam logic [15:0] ADDR_PIN_INPUT_ROUTE_D = 16'h200e;
    localparam logic [3:0] XDATA_REGION = 4'h2;

    // Field positions
    localparam int CE_ENABLE_BIT = 4;
    localparam int CHOP_LSB = 4;
    localparam int CLOCK_OUTPUT_DISABLE_BIT = 4;
    localparam int CONVERTER_DISABLE_BIT = 3;
    localparam int ROUTE_LO_LSB = 0;
    localparam int ROUTE_HI_LSB = 4;

    // Write masks and fixed read bits
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_RESERVED_THREE = 8'h18;
    localparam logic [7:0] MASK_ROUTE = 8'h77;
    localparam logic [7:0] MASK_DIRECTION = 8'hf0;
    localparam logic [7:0] DIRECTION_FIXED_ONES = 8'h0f;

    // Reset values
    localparam logic [7:0] RESET_VALUE = 8'h00;

    localparam int NUM_ROUTE_PINS = 8;
    localparam int NUM_ROUTE_REGS = 4;

    // Pin route codes
    localparam logic [2:0] ROUTE_NONE = 3'h0;
    localparam logic [2:0] ROUTE_RESERVED = 3'h1;
    localparam logic [2:0] ROUTE_COUNTER_ZERO_CLOCK = 3'h2;
    localparam logic [2:0] ROUTE_COUNTER_ONE_CLOCK = 3'h3;
    localparam logic [2:0] ROUTE_HIGH_RISING = 3'h4;
    localparam logic [2:0] ROUTE_LOW_RISING = 3'h5;
    localparam logic [2:0] ROUTE_HIGH_FALLING = 3'h6;
    localparam logic [2:0] ROUTE_LOW_FALLING = 3'h7;

    // Processor access request
    typedef struct packed {
        logic sfr_space;
        logic write;
        logic read;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cfg_req_type;

    // Resources fed by the routed pins
    typedef struct packed {
        logic counter_zero_clock;
        logic counter_one_clock;
        logic high_priority_pin_interrupt;
        logic low_priority_pin_interrupt;
    } route_out_type;

endpackage

/* test/meter_config_ram_bank_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module meter_config_ram_bank_properties (
    // Clock, reset and access
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire cfg_ram_pkg::cfg_req_type I_REQ,
    // Watched outputs
    input wire logic [7:0] O_RDATA,
    input wire logic O_RVALID,
    input wire logic O_CONVERTER_DISABLE,
    input wire logic O_CONVERTER_BIAS_OFF,
    input wire logic O_CE_RUN,
    input wire logic O_CHOP_ENABLE,
    input wire logic O_CLOCK_TEST_PIN,
    input wire logic O_CLOCK_TEST_PIN_OE_N,
    input wire cfg_ram_pkg::route_out_type O_ROUTE
);
    import cfg_ram_pkg::*;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);
    wire logic xw = I_REQ.write && !I_REQ.sfr_space;
    wire logic xr = I_REQ.read && !I_REQ.sfr_space;
    property p_reset;
        disable iff (1'b0) !I_RSTN |=> !O_RVALID && !O_CE_RUN &&
            O_ROUTE == '0 && O_CHOP_ENABLE && !O_CLOCK_TEST_PIN_OE_N;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset state");
    property p_rvalid;
        1 |=> O_RVALID == $past(I_REQ.read);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("rvalid off");
    property p_ce;
        xw && I_REQ.addr == 16'h2000 |->
            ##2 O_CE_RUN == $past(I_REQ.wdata[4], 2);
    endproperty
    a_ce: assert property (p_ce) else $error("engine run off");
    property p_conv;
        xw && I_REQ.addr == 16'h2005 |->
            ##2 O_CONVERTER_DISABLE == $past(I_REQ.wdata[3], 2) &&
            O_CONVERTER_BIAS_OFF == O_CONVERTER_DISABLE;
    endproperty
    a_conv: assert property (p_conv) else $error("converter off");
    property p_chop;
        xw && I_REQ.addr == 16'h2002 |-> ##2 O_CHOP_ENABLE ==
            ($past(I_REQ.wdata[5], 2) == $past(I_REQ.wdata[4], 2));
    endproperty
    a_chop: assert property (p_chop) else $error("chop off");
    property p_oe;
        xw && I_REQ.addr == 16'h2004 |->
            ##2 O_CLOCK_TEST_PIN_OE_N == $past(I_REQ.wdata[4], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("test pin enable off");
    property p_toggle;
        !O_CLOCK_TEST_PIN_OE_N [*3] |->
            O_CLOCK_TEST_PIN != $past(O_CLOCK_TEST_PIN);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");
    property p_ro;
        xr && I_REQ.addr == 16'h2003 |=> (O_RDATA & 8'he7) == 8'h00;
    endproperty
    a_ro: assert property (p_ro) else $error("read-only bits set");
    property p_sfr;
        I_REQ.read && I_REQ.sfr_space && I_REQ.addr == 16'h00a2 |=>
            O_RDATA[3:0] == 4'hf;
    endproperty
    a_sfr: assert property (p_sfr) else $error("fixed ones lost");
    c_route: cover property (xw && I_REQ.addr == 16'h200b);
    c_high: cover property (O_ROUTE.high_priority_pin_interrupt);
    c_count: cover property (O_ROUTE.counter_zero_clock);
endmodule // meter_config_ram_bank_properties
`default_nettype wire

/* test/meter_config_ram_bank_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module meter_config_ram_bank_tb_top;
    import cfg_ram_pkg::*;
    logic I_CLK_SYS, cdis, boff, ce, chop, ck, oen, rvalid;
    logic I_RSTN = 1'b0;
    cfg_req_type req = '0;
    logic [7:0] pin = 8'h00, rdata;
    logic [3:0] dir;
    route_out_type route;
    int n_mismatch = 0, num_checks = 0, hp = 0, lp = 0;
    logic [7:0] exq[$];
    logic [15:0] ad[10] = '{16'h00a2, 16'h2000, 16'h2002, 16'h2003,
        16'h2004, 16'h2005, 16'h200b, 16'h200c, 16'h200d, 16'h200e};
    logic [7:0] mk[10] = '{8'hf0, 8'hff, 8'hff, 8'h18, 8'hff, 8'hff,
        8'h77, 8'h77, 8'h77, 8'h77};
    meter_config_ram_bank meter_config_ram_bank_inst (.I_CLK_SYS(I_CLK_SYS),
        .I_RSTN(I_RSTN), .I_REQ(req), .O_RDATA(rdata), .O_RVALID(rvalid),
        .I_PIN(pin), .O_CONVERTER_DISABLE(cdis), .O_CONVERTER_BIAS_OFF(boff),
        .O_CE_RUN(ce), .O_CHOP_ENABLE(chop), .O_CLOCK_TEST_PIN(ck),
        .O_CLOCK_TEST_PIN_OE_N(oen), .O_PORT0_DIRECTION_BITS(dir),
        .O_ROUTE(route));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic acc(input logic sf, w, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge I_CLK_SYS);
        req <= '{sf, w, !w, a, d};
        @(posedge I_CLK_SYS);
        req <= '0;
    endtask
    task automatic rd(input logic sf, input logic [15:0] a,
        input logic [7:0] e);
        exq.push_back(e);
        acc(sf, 1'b0, a, 8'h00);
    endtask
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        I_CLK_SYS = 1'b0;
        forever #5 I_CLK_SYS = ~I_CLK_SYS;
    end
    always @(posedge I_CLK_SYS) begin
        if (rvalid === 1'b1) chk(rdata, exq.pop_front());
        hp <= hp + int'(route.high_priority_pin_interrupt === 1'b1);
        lp <= lp + int'(route.low_priority_pin_interrupt === 1'b1);
    end
    initial begin
        #60000;
        n_mismatch++;
        final_report;
    end
    initial begin
        logic [7:0] w[10];
        int h0, l0;
        logic k;
        void'($urandom(32'h17d3_526f));
        repeat (4) @(posedge I_CLK_SYS);
        I_RSTN <= 1'b1;
        for (int i = 0; i < 10; i++) rd(i == 0, ad[i], 8'(i == 0) * 8'h0f);
        for (int i = 0; i < 10; i++) begin
            w[i] = 8'($urandom()) & ~((i == 3) ? 8'h18 :
                (i == 4) ? 8'h20 : 8'h00);
            acc(i == 0, 1'b1, ad[i], w[i]);
            rd(i == 0, ad[i], (w[i] & mk[i]) | (8'(i == 0) * 8'h0f));
        end
        repeat (2) @(posedge I_CLK_SYS);
        chk(dir, w[0][7:4]);
        chk(ce, w[1][4]);
        chk({cdis, boff}, {2{w[5][3]}});
        chk(oen, w[4][4]);
        for (int v = 0; v < 2; v++) begin
            acc(1'b0, 1'b1, 16'h2000, 8'(v << 4));
            acc(1'b0, 1'b1, 16'h2004, 8'(v << 4));
            acc(1'b0, 1'b1, 16'h2005, 8'(v << 3));
            repeat (2) @(posedge I_CLK_SYS);
            chk(ce, v[0]);
            chk(oen, v[0]);
            chk({cdis, boff}, {2{v[0]}});
            k = ck;
            @(posedge I_CLK_SYS);
            chk(ck, (v == 1) ? 1'b0 : !k);
        end
        for (int c = 0; c < 4; c++) begin
            acc(1'b0, 1'b1, 16'h2002, 8'(c << 4));
            repeat (2) @(posedge I_CLK_SYS);
            chk(chop, c == 0 || c == 3);
        end
        acc(1'b0, 1'b1, 16'h2001, 8'hff);
        rd(1'b0, 16'h2001, 8'h00);
        rd(1'b1, 16'h2000, 8'h00);
        acc(1'b0, 1'b1, 16'h200d, 8'h00);
        acc(1'b0, 1'b1, 16'h200e, 8'h00);
        for (int c = 0; c < 8; c++) begin
            acc(1'b0, 1'b1, 16'h200b, 8'(c));
            acc(1'b0, 1'b1, 16'h200c, 8'(c));
            repeat (2) @(posedge I_CLK_SYS);
            h0 = hp;
            l0 = lp;
            for (int s = 0; s < 4; s++) begin
                pin <= (s == 0) ? 8'h01 : (s == 1) ? 8'h05 : (s == 2) ? 8'h04 : 8'h00;
                repeat (6) @(posedge I_CLK_SYS);
                chk(route.counter_zero_clock, s < 3 && c == 2);
                chk(route.counter_one_clock, s < 3 && c == 3);
            end
            chk(8'(hp - h0), 8'(2 * (c == 4 || c == 6)));
            chk(8'(lp - l0), 8'(2 * (c == 5 || c == 7)));
        end
        I_RSTN <= 1'b0;
        repeat (4) @(posedge I_CLK_SYS);
        I_RSTN <= 1'b1;
        for (int i = 0; i < 10; i++)
            rd(i == 0, ad[i], 8'(i == 0) * 8'h0f);
        chk({cdis, boff, ce, oen}, 8'h00);
        chk(chop, 1'b1);
        chk(dir, 4'h0);
        final_report;
    end
endmodule // meter_config_ram_bank_tb_top
bind meter_config_ram_bank meter_config_ram_bank_properties
    meter_config_ram_bank_properties_inst (.I_CLK_SYS(I_CLK_SYS),
    .I_RSTN(I_RSTN), .I_REQ(I_REQ), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
    .O_CONVERTER_DISABLE(O_CONVERTER_DISABLE), .O_CE_RUN(O_CE_RUN),
    .O_CONVERTER_BIAS_OFF(O_CONVERTER_BIAS_OFF), .O_ROUTE(O_ROUTE),
    .O_CHOP_ENABLE(O_CHOP_ENABLE), .O_CLOCK_TEST_PIN(O_CLOCK_TEST_PIN),
    .O_CLOCK_TEST_PIN_OE_N(O_CLOCK_TEST_PIN_OE_N));
`default_nettype wire
